// ===== core/link_timing_pkg.sv
// constants and carrier types for the radio link timing block
// assumes a 10 MHz system clock and a host-side command decoder
`default_nettype none

package link_timing_pkg;

   // ==============================
   // command codes
   localparam logic [7:0] CMD_SLEEP_IDLE   = 8'h02;
   localparam logic [7:0] CMD_CHAN_HOLD    = 8'h17;
   localparam logic [7:0] CMD_STREAM_LIMIT = 8'h1a;
   localparam logic [7:0] CMD_DROPPED      = 8'h1b;

   // ==============================
   // reset values and ranges
   localparam logic [15:0] SLEEP_IDLE_RST   = 16'h0064;
   localparam logic [15:0] SLEEP_IDLE_MIN   = 16'h0010;
   localparam logic [7:0]  CHAN_HOLD_RST    = 8'h00;
   localparam logic [15:0] STREAM_LIMIT_RST = 16'hffff;
   localparam logic [15:0] DROPPED_RST      = 16'h0000;

   // ==============================
   // sleep selection codes
   localparam logic [3:0] SLEEP_SEL_OFF       = 4'h0;
   localparam logic [3:0] SLEEP_SEL_PIN       = 4'h1;
   localparam logic [3:0] SLEEP_SEL_SERIAL    = 4'h2;
   localparam logic [3:0] SLEEP_SEL_CYC_FIRST = 4'h3;
   localparam logic [3:0] SLEEP_SEL_CYC_LAST  = 4'h8;

   // ==============================
   // timing
   localparam int CLK_HZ        = 10_000_000;
   localparam int TICK_MS       = 100;
   localparam int SLOT_MS       = 38;
   localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
   localparam int SLOT_CYCLES   = CLK_HZ / 1000 * SLOT_MS;
   localparam logic [15:0] LFSR_SEED = 16'hace1;

   // ==============================
   // carriers
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] code;
      logic [15:0] data;
   } cmd_req_t;

   typedef struct packed {
      logic       valid;
      logic       ok;
      logic [1:0] nbytes;
      logic [15:0] data;
   } cmd_rsp_t;

endpackage : link_timing_pkg

`default_nettype wire

// ===== core/byte_fifo.sv
// parameterised valid/ready fifo, flip-flop storage
// assumes single clock, async active-low reset
`default_nettype none

module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_in,
   input  wire logic             rstn_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   input  wire logic [WIDTH-1:0] wr_data_in,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in,
   output logic      [WIDTH-1:0] rd_data_out
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wp_ff;
   logic [AW-1:0]    rp_ff;
   logic [AW:0]      cnt_ff;
   logic             push;
   logic             pop;

   assign wr_ready_out = (cnt_ff != (AW+1)'(DEPTH));
   assign rd_valid_out = (cnt_ff != '0);
   assign push         = wr_valid_in && wr_ready_out;
   assign pop          = rd_valid_out && rd_ready_in;
   assign rd_data_out  = mem_ff[rp_ff];

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_ff[wp_ff] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wp_ff  <= '0;
         rp_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
         end
         if (pop) begin
            rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule : byte_fifo

`default_nettype wire

// ===== core/link_timing.sv
// timing and counting behind four radio configuration parameters
// assumes a command decoder on the same clock and an rf engine that
// reports activity, retry exhaustion and session breaks as pulses
`default_nettype none

// Function
// R1: idle time 0x10..0xffff, 100ms units, 2 bytes
// R2: idle time resets to 0x64
// R3: sleep after idle period; activity restarts it
// R4: idle timer only in cyclic/serial sleep
// R5: hold time 8 bits, 100ms units, 1 byte
// R6: zero hold: per-packet session, always sync
// R7: nonzero hold keeps channel open on activity
// R8: sync resent only after pause beyond hold
// R9: host sets hold 100ms above gap
// R10: broken session blocks channel until hold expires
// R11: count packets unacked after all retries
// R12: dropped counter 16 bits, 2 bytes
// R13: dropped counter cleared on reset
// R14: count streamed bytes; at limit, random delay
// R15: limit 16 bits; zero disables delay
// R16: limit resets to 0xffff
// R17: delay 1..span+1 slots of 38ms
// R18: codes 0x02 idle, 0x17 hold
// R19: codes 0x1b dropped, 0x1a limit
// R20: selection 0 off, 1 pin, 3..8 cyclic
// R21: slot count from free-running lfsr
// R22: prescaled ticks, timers restart on reset
module link_timing #(
   parameter int TICK_CYCLES = link_timing_pkg::TICK_CYCLES,
   parameter int SLOT_CYCLES = link_timing_pkg::SLOT_CYCLES,
   parameter int FIFO_DEPTH  = 4
) (
   input  wire logic                      clk_in,
   input  wire logic                      rstn_in,
   input  wire link_timing_pkg::cmd_req_t cmd_in,
   output link_timing_pkg::cmd_rsp_t      rsp_out,
   input  wire logic [3:0]                sleep_selection_in,
   input  wire logic [7:0]                backoff_slot_span_in,
   input  wire logic                      tx_activity_in,
   input  wire logic                      rx_activity_in,
   input  wire logic                      retry_exhausted_in,
   input  wire logic                      session_break_in,
   input  wire logic                      tx_byte_valid_in,
   output logic                           tx_byte_ready_out,
   input  wire logic [7:0]                tx_byte_in,
   output logic                           rf_byte_valid_out,
   input  wire logic                      rf_byte_ready_in,
   output logic      [7:0]                rf_byte_out,
   output logic                           sleep_req_out,
   output logic                           channel_open_out,
   output logic                           channel_blocked_out,
   output logic                           send_sync_out,
   output logic                           backoff_active_out
);
   // ==============================
   // registers
   logic [15:0] sleep_idle_time_ff;
   logic [7:0]  channel_hold_time_ff;
   logic [15:0] stream_byte_limit_ff;
   logic [15:0] dropped_packet_count_ff;
   link_timing_pkg::cmd_rsp_t rsp_ff;

   function automatic logic [15:0] clamp_idle(input logic [15:0] v);
      return (v < link_timing_pkg::SLEEP_IDLE_MIN) ?
             link_timing_pkg::SLEEP_IDLE_MIN : v;
   endfunction : clamp_idle

   // true on the tick that completes the hold period
   function automatic logic hold_done(input logic [7:0] cnt,
                                      input logic [7:0] hold);
      return (8'(cnt + 8'h01) >= hold);
   endfunction : hold_done

   // config registers, host write path
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sleep_idle_time_ff   <= link_timing_pkg::SLEEP_IDLE_RST; // R2
         channel_hold_time_ff <= link_timing_pkg::CHAN_HOLD_RST; // R6
         stream_byte_limit_ff <= link_timing_pkg::STREAM_LIMIT_RST; // R16
      end else if (cmd_in.valid && cmd_in.write) begin
         case (cmd_in.code)
            link_timing_pkg::CMD_SLEEP_IDLE: begin
               sleep_idle_time_ff <= clamp_idle(cmd_in.data); // R1 R18
            end
            link_timing_pkg::CMD_CHAN_HOLD: begin
               channel_hold_time_ff <= cmd_in.data[7:0]; // R5 R18
            end
            link_timing_pkg::CMD_STREAM_LIMIT: begin
               stream_byte_limit_ff <= cmd_in.data; // R15 R19
            end
            default: begin
            end
         endcase
      end
   end

   // response path, one cycle after the command
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rsp_ff <= '0;
      end else begin
         rsp_ff.valid <= cmd_in.valid;
         rsp_ff.ok    <= 1'b1;
         rsp_ff.data  <= 16'h0000;
         case (cmd_in.code)
            link_timing_pkg::CMD_SLEEP_IDLE: begin
               rsp_ff.nbytes <= 2'd2; // R1
               rsp_ff.data   <= cmd_in.write ? clamp_idle(cmd_in.data)
                                             : sleep_idle_time_ff;
            end
            link_timing_pkg::CMD_CHAN_HOLD: begin
               rsp_ff.nbytes <= 2'd1; // R5
               rsp_ff.data   <= cmd_in.write ? {8'h00, cmd_in.data[7:0]}
                                             : {8'h00, channel_hold_time_ff};
            end
            link_timing_pkg::CMD_STREAM_LIMIT: begin
               rsp_ff.nbytes <= 2'd2;
               rsp_ff.data   <= cmd_in.write ? cmd_in.data
                                             : stream_byte_limit_ff;
            end
            link_timing_pkg::CMD_DROPPED: begin
               rsp_ff.nbytes <= 2'd2; // R12 R19
               rsp_ff.ok     <= !cmd_in.write;
               rsp_ff.data   <= dropped_packet_count_ff;
            end
            default: begin
               rsp_ff.nbytes <= 2'd0;
               rsp_ff.ok     <= 1'b0;
            end
         endcase
      end
   end
   assign rsp_out = rsp_ff;

   // ==============================
   // prescalers
   logic [$clog2(TICK_CYCLES)-1:0] tick_div_ff;
   logic [$clog2(SLOT_CYCLES)-1:0] slot_div_ff;
   logic tick_100ms;
   logic tick_slot;

   assign tick_100ms = (tick_div_ff == ($bits(tick_div_ff))'(TICK_CYCLES-1));
   assign tick_slot  = (slot_div_ff == ($bits(slot_div_ff))'(SLOT_CYCLES-1));

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tick_div_ff <= '0; // R22
      end else begin
         tick_div_ff <= tick_100ms ? '0 : tick_div_ff + 1'b1; // R22
      end
   end

   // ==============================
   // sleep idle timer
   logic        activity;
   logic        sleep_gated;
   logic [15:0] idle_cnt_ff;

   assign activity = tx_activity_in || rx_activity_in;
   assign sleep_gated = (sleep_selection_in == link_timing_pkg::SLEEP_SEL_SERIAL)
      || ((sleep_selection_in >= link_timing_pkg::SLEEP_SEL_CYC_FIRST)
      && (sleep_selection_in <= link_timing_pkg::SLEEP_SEL_CYC_LAST)); // R4 R20

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         idle_cnt_ff   <= '0;
         sleep_req_out <= 1'b0;
      end else if (activity || !sleep_gated) begin
         idle_cnt_ff   <= '0; // R3
         sleep_req_out <= 1'b0; // R4
      end else if (tick_100ms && !sleep_req_out) begin
         idle_cnt_ff <= idle_cnt_ff + 1'b1;
         if (idle_cnt_ff + 16'h0001 >= sleep_idle_time_ff) begin
            sleep_req_out <= 1'b1; // R3
         end
      end
   end

   // ==============================
   // channel hold session
   logic [7:0] hold_cnt_ff;
   logic       session_ff;
   logic       blocked_ff;
   logic       hold_on;

   assign hold_on = (channel_hold_time_ff != 8'h00);

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hold_cnt_ff <= '0;
         session_ff  <= 1'b0;
         blocked_ff  <= 1'b0;
      end else if (!hold_on) begin
         hold_cnt_ff <= '0; // R6
         session_ff  <= 1'b0;
         blocked_ff  <= 1'b0;
      end else if (session_break_in && session_ff) begin
         session_ff  <= 1'b0;
         blocked_ff  <= 1'b1; // R10
         hold_cnt_ff <= '0;
      end else if (blocked_ff) begin
         if (tick_100ms) begin
            hold_cnt_ff <= hold_cnt_ff + 1'b1;
            if (hold_done(hold_cnt_ff, channel_hold_time_ff)) begin
               blocked_ff <= 1'b0; // R10
            end
         end
      end else if (activity) begin
         session_ff  <= 1'b1; // R7
         hold_cnt_ff <= '0;
      end else if (session_ff && tick_100ms) begin
         hold_cnt_ff <= hold_cnt_ff + 1'b1;
         if (hold_done(hold_cnt_ff, channel_hold_time_ff)) begin
            session_ff <= 1'b0; // R8
         end
      end
   end

   assign channel_open_out    = session_ff;
   assign channel_blocked_out = blocked_ff;
   assign send_sync_out       = !hold_on || !session_ff; // R6 R8

   // ==============================
   // dropped packet counter
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dropped_packet_count_ff <= link_timing_pkg::DROPPED_RST; // R13
      end else if (retry_exhausted_in) begin
         dropped_packet_count_ff <= dropped_packet_count_ff + 1'b1; // R11 R12
      end
   end

   // ==============================
   // streaming limit and random back-off
   logic [15:0] lfsr_ff;
   logic [15:0] byte_cnt_ff;
   logic [8:0]  slots_left_ff;
   logic        backoff_ff;
   logic        fifo_out_valid;
   logic        rf_take;
   logic [8:0]  span_p1;

   assign span_p1 = {1'b0, backoff_slot_span_in} + 9'd1;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         lfsr_ff <= link_timing_pkg::LFSR_SEED; // R22
      end else begin
         lfsr_ff <= {lfsr_ff[14:0],
                     lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]}; // R21
      end
   end

   byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in       (clk_in),
      .rstn_in      (rstn_in),
      .wr_valid_in  (tx_byte_valid_in),
      .wr_ready_out (tx_byte_ready_out),
      .wr_data_in   (tx_byte_in),
      .rd_valid_out (fifo_out_valid),
      .rd_ready_in  (rf_byte_ready_in && !backoff_ff),
      .rd_data_out  (rf_byte_out)
   );

   assign rf_byte_valid_out  = fifo_out_valid && !backoff_ff; // R14
   assign rf_take            = rf_byte_valid_out && rf_byte_ready_in;
   assign backoff_active_out = backoff_ff;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         byte_cnt_ff   <= '0;
         slots_left_ff <= '0;
         backoff_ff    <= 1'b0;
         slot_div_ff   <= '0;
      end else if (backoff_ff) begin
         slot_div_ff <= tick_slot ? '0 : slot_div_ff + 1'b1;
         if (tick_slot) begin
            slots_left_ff <= slots_left_ff - 9'd1; // R17
            if (slots_left_ff == 9'd1) begin
               backoff_ff <= 1'b0;
            end
         end
      end else if (rf_take) begin
         if (stream_byte_limit_ff != 16'h0000 &&
             byte_cnt_ff + 16'h0001 >= stream_byte_limit_ff) begin // R15
            byte_cnt_ff   <= '0;
            backoff_ff    <= 1'b1; // R14
            slot_div_ff   <= '0;
            slots_left_ff <= 9'((lfsr_ff[8:0] % span_p1) + 9'd1); // R17 R21
         end else begin
            byte_cnt_ff <= byte_cnt_ff + 1'b1; // R14
         end
      end else if (!fifo_out_valid) begin
         byte_cnt_ff <= '0; // stream ended
      end
   end

endmodule : link_timing

`default_nettype wire

// ===== sim/link_timing_properties.sv
// port assertions for the radio link timing block
// assumes binding onto link_timing from the bench top file
`default_nettype none

module link_timing_properties (
   input wire logic                      clk_in,
   input wire logic                      rstn_in,
   input wire link_timing_pkg::cmd_req_t cmd_in,
   input wire link_timing_pkg::cmd_rsp_t rsp_out,
   input wire logic [3:0]                sleep_selection_in,
   input wire logic                      tx_activity_in,
   input wire logic                      rx_activity_in,
   input wire logic                      rf_byte_valid_out,
   input wire logic                      sleep_req_out,
   input wire logic                      channel_open_out,
   input wire logic                      send_sync_out,
   input wire logic                      backoff_active_out
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   // ==============================
   // command bus
   a_rsp_follows:
      assert property (cmd_in.valid |=> rsp_out.valid)
      else $error("response missing after command");
   a_rsp_quiet:
      assert property (!cmd_in.valid |=> !rsp_out.valid)
      else $error("response without command");
   a_hold_width:
      assert property (cmd_in.valid && cmd_in.code == 8'h17 |=>
         rsp_out.nbytes == 2'd1 && rsp_out.data[15:8] == 8'h00)
      else $error("hold time answer not one byte");
   a_idle_width:
      assert property (cmd_in.valid && cmd_in.code == 8'h02 |=>
         rsp_out.ok && rsp_out.nbytes == 2'd2)
      else $error("idle time answer not two bytes");
   a_idle_clamp:
      assert property (cmd_in.valid && cmd_in.write &&
         cmd_in.code == 8'h02 && cmd_in.data < 16'h0010 |=>
         rsp_out.data == 16'h0010)
      else $error("idle time below range not clamped");
   a_count_ro:
      assert property (cmd_in.valid && cmd_in.write &&
         cmd_in.code == 8'h1b |=> !rsp_out.ok)
      else $error("dropped counter write accepted");

   // ==============================
   // timers and stream
   a_sleep_gate:
      assert property (sleep_selection_in < 4'h2 ||
         sleep_selection_in > 4'h8 |=> !sleep_req_out)
      else $error("sleep outside idle-timed selections");
   a_wake_on_act:
      assert property (tx_activity_in || rx_activity_in |=> !sleep_req_out)
      else $error("sleep despite activity");
   a_sync_closed:
      assert property (!channel_open_out |-> send_sync_out)
      else $error("sync withheld without session");
   a_backoff_gate:
      assert property (backoff_active_out |-> !rf_byte_valid_out)
      else $error("byte offered during backoff");
endmodule : link_timing_properties

`default_nettype wire

// ===== sim/host_cmd_model.sv
// host controller model issuing configuration commands
// assumes the answer stands one cycle after the command edge
`default_nettype none

module host_cmd_model (
   input  wire logic                      clk_in,
   output link_timing_pkg::cmd_req_t      cmd_out,
   input  wire link_timing_pkg::cmd_rsp_t rsp_in
);
   timeunit 1ns;
   timeprecision 100ps;

   initial cmd_out = '0;

   task automatic xfer(input logic wr, input logic [7:0] c,
                       input logic [15:0] d,
                       output link_timing_pkg::cmd_rsp_t rsp);
      @(posedge clk_in);
      #1;
      cmd_out = '{valid: 1'b1, write: wr, code: c, data: d};
      @(posedge clk_in);
      #1;
      cmd_out = '0;
      rsp = rsp_in;
   endtask : xfer
endmodule : host_cmd_model

`default_nettype wire

// ===== sim/link_timing_tb_top.sv
// self-checking bench for the radio link timing block
// assumes the package, design, host model and checker compiled first
`default_nettype none

module link_timing_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TK = 20;
   logic clk_in, rstn_in, tx_act, rx_act, retry_ex, brk, tx_v, rf_rdy;
   logic [3:0] sel;
   logic [7:0] span, tx_d, rf_d;
   logic tx_rdy, rf_v, slp, opn, blk, syn, bo;
   link_timing_pkg::cmd_req_t cmd;
   link_timing_pkg::cmd_rsp_t rsp, r;
   int n_fail = 0;
   int cmp_count = 0;
   int n;

   link_timing #(.TICK_CYCLES(TK), .SLOT_CYCLES(8), .FIFO_DEPTH(4))
   u_link_timing (.clk_in(clk_in), .rstn_in(rstn_in), .cmd_in(cmd),
      .rsp_out(rsp), .sleep_selection_in(sel),
      .backoff_slot_span_in(span), .tx_activity_in(tx_act),
      .rx_activity_in(rx_act), .retry_exhausted_in(retry_ex),
      .session_break_in(brk), .tx_byte_valid_in(tx_v),
      .tx_byte_ready_out(tx_rdy), .tx_byte_in(tx_d),
      .rf_byte_valid_out(rf_v), .rf_byte_ready_in(rf_rdy),
      .rf_byte_out(rf_d), .sleep_req_out(slp), .channel_open_out(opn),
      .channel_blocked_out(blk), .send_sync_out(syn),
      .backoff_active_out(bo));
   host_cmd_model u_host_cmd_model (.clk_in(clk_in), .cmd_out(cmd),
      .rsp_in(rsp));

   // ==============================
   // tasks
   task automatic step(input int k = 1);
      repeat (k) @(posedge clk_in);
      #1;
   endtask : step
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic flg(input logic g, input logic e);
      chk({15'h0, g}, {15'h0, e});
   endtask : flg
   task automatic rd(input logic [7:0] c, input logic [15:0] e,
                     input logic [1:0] nb);
      u_host_cmd_model.xfer(1'b0, c, 16'h0000, r);
      chk({13'h0, r.ok, r.nbytes}, {13'h0, nb != 2'd0, nb});
      chk(r.data, e);
   endtask : rd
   task automatic wr(input logic [7:0] c, input logic [15:0] d,
                     input logic ok);
      u_host_cmd_model.xfer(1'b1, c, d, r);
      flg(r.ok, ok);
   endtask : wr
   task automatic act;
      tx_act = 1'b1;
      step();
      tx_act = 1'b0;
   endtask : act
   task automatic reset_dut;
      rstn_in = 1'b0;
      step(6);
      rstn_in = 1'b1;
      rd(8'h02, 16'h0064, 2'd2);
      rd(8'h17, 16'h0000, 2'd1);
      rd(8'h1a, 16'hffff, 2'd2);
      rd(8'h1b, 16'h0000, 2'd2);
   endtask : reset_dut
   task automatic stream(input logic [15:0] lim, input logic [7:0] sp);
      int acc, nb, nbo, at;
      acc = 0;
      nb = 0;
      nbo = 0;
      at = -1;
      wr(8'h1a, lim, 1'b1);
      span = sp;
      rf_rdy = 1'b0;
      repeat (6) begin
         tx_v = 1'b1;
         tx_d = 8'ha0 + acc[7:0];
         acc += int'(tx_rdy);
         step();
      end
      tx_v = 1'b0;
      rf_rdy = 1'b1;
      repeat (50) begin
         if (bo && at < 0) at = nb;
         nbo += int'(bo);
         if (rf_v) begin
            chk({8'h0, rf_d}, {8'h0, 8'ha0 + nb[7:0]});
            nb++;
         end
         step();
      end
      chk(acc[15:0], 16'd4);
      chk(nb[15:0], 16'd4);
      if (lim == 16'h0) begin
         chk(nbo[15:0], 16'h0);
      end else begin
         chk(at[15:0], lim);
         flg(nbo % 8 == 0 && nbo >= 8 && nbo <= 8 * (sp + 1), 1'b1);
      end
      $display("test stream %h done", lim);
   endtask : stream
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish

   // ==============================
   // clock, watchdog and tests
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   initial begin
      #2_000_000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      {rstn_in, tx_act, rx_act, retry_ex, brk, tx_v, rf_rdy} = '0;
      {sel, span, tx_d} = '0;
      reset_dut();
      rd(8'h05, 16'h0000, 2'd0);
      wr(8'h02, 16'h0005, 1'b1);
      rd(8'h02, 16'h0010, 2'd2);
      wr(8'h02, 16'hffff, 1'b1);
      rd(8'h02, 16'hffff, 2'd2);
      repeat (3) begin
         retry_ex = 1'b1;
         step();
         retry_ex = 1'b0;
      end
      wr(8'h1b, 16'h0009, 1'b0);
      rd(8'h1b, 16'h0003, 2'd2);
      reset_dut();
      $display("test registers done");
      wr(8'h02, 16'h0010, 1'b1);
      for (int s = 0; s < 9; s++) begin
         sel = s[3:0];
         act();
         n = 0;
         while (slp !== 1'b1 && n < 360) begin
            step();
            n++;
         end
         flg(s < 2 ? n == 360 : n >= 14 * TK && n <= 17 * TK + 5,
             1'b1);
         rx_act = 1'b1;
         step();
         rx_act = 1'b0;
         flg(slp, 1'b0);
      end
      sel = 4'h0;
      $display("test sleep done");
      wr(8'h17, 16'h0003, 1'b1);
      rd(8'h17, 16'h0003, 2'd1);
      act();
      step();
      chk({14'h0, opn, syn}, 16'h0002);
      repeat (4) begin
         step(30);
         act();
      end
      flg(opn, 1'b1);
      step(100);
      chk({14'h0, opn, syn}, 16'h0001);
      act();
      brk = 1'b1;
      step();
      brk = 1'b0;
      step(30);
      flg(blk, 1'b1);
      step(80);
      flg(blk, 1'b0);
      wr(8'h17, 16'h0000, 1'b1);
      act();
      flg(syn, 1'b1);
      $display("test hold done");
      stream(16'h0003, 8'h00);
      stream(16'h0003, 8'h03);
      stream(16'h0000, 8'h00);
      tally_and_finish();
   end
endmodule : link_timing_tb_top

bind link_timing link_timing_properties u_link_timing_properties (
   .clk_in(clk_in), .rstn_in(rstn_in), .cmd_in(cmd_in),
   .rsp_out(rsp_out), .sleep_selection_in(sleep_selection_in),
   .tx_activity_in(tx_activity_in), .rx_activity_in(rx_activity_in),
   .rf_byte_valid_out(rf_byte_valid_out), .sleep_req_out(sleep_req_out),
   .channel_open_out(channel_open_out), .send_sync_out(send_sync_out),
   .backoff_active_out(backoff_active_out));

`default_nettype wire
